// File: rtl/rsx_pkg.sv
// Package of opcodes, field widths and carriers for the byte datapath slice
package rsx_pkg;
	localparam int DATA_W     = 8;
	localparam int ADDR_W     = 5;
	localparam int FILE_DEPTH = 32;
	localparam int NIB_LO     = 0;
	localparam int NIB_HI     = 4;
	localparam int NIB_W      = 4;
	localparam logic [DATA_W-1:0] ACC_RESET   = 8'h00;
	localparam logic [DATA_W-1:0] DIR_RESET   = 8'hff;
	localparam logic [DATA_W-1:0] FILE_RESET  = 8'h00;
	localparam logic              CARRY_RESET = 1'b0;
	localparam logic              ZERO_RESET  = 1'b0;
	localparam logic [ADDR_W-1:0] DIR_SEL_A   = 5'h06;
	localparam logic [ADDR_W-1:0] DIR_SEL_B   = 5'h07;
	localparam logic              DEST_ACC    = 1'b0;

	// Decoded operation, Gray coded along the usual order
	typedef enum logic [2:0] {
		RSX_NOP                   = 3'h0,
		RSX_ROTATE_RIGHT_CARRY_OP = 3'h1,
		RSX_NIBBLE_EXCHANGE_OP    = 3'h3,
		RSX_XOR_FILE_ACCUM_OP     = 3'h2,
		RSX_XOR_LITERAL_ACCUM_OP  = 3'h6,
		RSX_PORT_DIRECTION_LOAD_OP = 3'h7
	} rsx_op_type;

	// One decoded instruction from the decoder
	typedef struct packed {
		rsx_op_type              op;
		logic [ADDR_W-1:0]       addr;
		logic                    dest;
		logic [DATA_W-1:0]       literal;
	} rsx_instr_type;

	// Status flags kept by the slice
	typedef struct packed {
		logic carry;
		logic zero;
	} rsx_flags_type;
endpackage

// File: rtl/rsx_datapath.sv
// Datapath slice: rotate, nibble swap, exclusive OR and direction loads
`timescale 1ns/100ps
module rsx_datapath
	import rsx_pkg::*;
(
	input  wire logic          sys_clk_i,   // Instruction clock
	input  wire logic          reset_n_i,   // Async reset, active low
	input  wire logic          valid_i,     // Instruction present this cycle
	input  wire rsx_instr_type instr_i,     // Decoded instruction
	output logic [DATA_W-1:0]  accum_o,     // Accumulator
	output rsx_flags_type      flags_o,     // Carry and zero flags
	output logic [DATA_W-1:0]  dir_a_o,     // Direction register 6
	output logic [DATA_W-1:0]  dir_b_o,     // Direction register 7
	output logic [DATA_W-1:0]  rd_data_o,   // Last file read value
	output logic               file_we_o    // File written last cycle
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [DATA_W-1:0] file_mem [FILE_DEPTH];
	logic [DATA_W-1:0] accum, next_accum;
	rsx_flags_type     flags, next_flags;
	logic [DATA_W-1:0] dir_a, next_dir_a;
	logic [DATA_W-1:0] dir_b, next_dir_b;
	logic [DATA_W-1:0] rd_data, next_rd_data;
	logic              file_we, next_file_we;
	logic [DATA_W-1:0] result;
	logic [DATA_W-1:0] src;

	assign src = file_mem[instr_i.addr];

	// ------------------------------------------------------------
	// Next-state computation
	// ------------------------------------------------------------
	// One result path shared by all file operations, steered by dest
	always_comb begin
		next_accum   = accum;
		next_flags   = flags;
		next_dir_a   = dir_a;
		next_dir_b   = dir_b;
		next_rd_data = rd_data;
		next_file_we = 1'b0;
		result       = src;
		if (valid_i) begin
			next_rd_data = src;
			case (instr_i.op)
				RSX_ROTATE_RIGHT_CARRY_OP: begin
					result = {flags.carry, src[DATA_W-1:1]};
					next_flags.carry = src[0];
				end
				RSX_NIBBLE_EXCHANGE_OP: begin
					result = {src[NIB_LO +: NIB_W],
						src[NIB_HI +: NIB_W]};
				end
				RSX_XOR_FILE_ACCUM_OP: begin
					result = accum ^ src;
					next_flags.zero = (result == '0);
				end
				RSX_XOR_LITERAL_ACCUM_OP: begin
					result = accum ^ instr_i.literal;
					next_flags.zero = (result == '0);
					next_accum = result;
				end
				RSX_PORT_DIRECTION_LOAD_OP: begin
					// Other selectors are ignored; only rd_data takes the file value
					if (instr_i.addr == DIR_SEL_A)
						next_dir_a = accum;
					else if (instr_i.addr == DIR_SEL_B)
						next_dir_b = accum;
				end
				default: begin
					result = src;
				end
			endcase
			if (instr_i.op == RSX_ROTATE_RIGHT_CARRY_OP ||
			    instr_i.op == RSX_NIBBLE_EXCHANGE_OP ||
			    instr_i.op == RSX_XOR_FILE_ACCUM_OP) begin
				if (instr_i.dest == DEST_ACC)
					next_accum = result;
				else
					next_file_we = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// File array cleared on reset: costs reset wiring per bit,
	// but a read before the first write is never unknown
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < FILE_DEPTH; i++) begin
				file_mem[i] <= FILE_RESET;
			end
		end else if (next_file_we) begin
			file_mem[instr_i.addr] <= result;
		end
	end

	// Control state with defined reset values
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			accum   <= ACC_RESET;
			flags   <= '{carry: CARRY_RESET, zero: ZERO_RESET};
			dir_a   <= DIR_RESET;
			dir_b   <= DIR_RESET;
			rd_data <= ACC_RESET;
			file_we <= 1'b0;
		end else begin
			accum   <= next_accum;
			flags   <= next_flags;
			dir_a   <= next_dir_a;
			dir_b   <= next_dir_b;
			rd_data <= next_rd_data;
			file_we <= next_file_we;
		end
	end

	assign accum_o   = accum;
	assign flags_o   = flags;
	assign dir_a_o   = dir_a;
	assign dir_b_o   = dir_b;
	assign rd_data_o = rd_data;
	assign file_we_o = file_we;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// Rotate: carry takes bit 0, old carry enters bit 7
	rot_carry_a: assert property (
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		valid_i && instr_i.op == RSX_ROTATE_RIGHT_CARRY_OP |=>
		flags.carry == $past(src[0]) && flags.zero == $past(flags.zero))
		else $error("rotate carry wrong");
	rot_msb_a: assert property (
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		valid_i && instr_i.op == RSX_ROTATE_RIGHT_CARRY_OP && !instr_i.dest
		|=> accum == {$past(flags.carry), $past(src[DATA_W-1:1])})
		else $error("rotate result wrong");
	rot_file_a: assert property (
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		valid_i && instr_i.op == RSX_ROTATE_RIGHT_CARRY_OP && instr_i.dest
		|=> file_mem[$past(instr_i.addr)] ==
		{$past(flags.carry), $past(src[DATA_W-1:1])})
		else $error("rotate write-back wrong");

	// Destination steering for the three file operations
	dest_file_a: assert property (
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		valid_i && instr_i.dest && instr_i.op != RSX_XOR_LITERAL_ACCUM_OP &&
		instr_i.op != RSX_PORT_DIRECTION_LOAD_OP && instr_i.op != RSX_NOP
		|=> $stable(accum) && file_we)
		else $error("destination steering wrong");
	dest_acc_a: assert property (
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		valid_i && !instr_i.dest |=> !file_we)
		else $error("file written for accumulator destination");

	// Swap exchanges nibbles on either path, flags held
	swap_res_a: assert property (
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		valid_i && instr_i.op == RSX_NIBBLE_EXCHANGE_OP && !instr_i.dest
		|=> accum == {$past(src[NIB_LO +: NIB_W]),
		$past(src[NIB_HI +: NIB_W])} && $stable(flags))
		else $error("swap wrong");
	swap_file_a: assert property (
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		valid_i && instr_i.op == RSX_NIBBLE_EXCHANGE_OP && instr_i.dest
		|=> file_mem[$past(instr_i.addr)] ==
		{$past(src[NIB_LO +: NIB_W]), $past(src[NIB_HI +: NIB_W])} &&
		$stable(flags))
		else $error("swap write-back wrong");

	// Direction loads copy the accumulator; other selectors refused
	dir_load_a: assert property (
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		valid_i && instr_i.op == RSX_PORT_DIRECTION_LOAD_OP &&
		instr_i.addr == DIR_SEL_B
		|=> dir_b == $past(accum) && $stable(flags))
		else $error("direction load wrong");
	dir_first_a: assert property (
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		valid_i && instr_i.op == RSX_PORT_DIRECTION_LOAD_OP &&
		instr_i.addr == DIR_SEL_A
		|=> dir_a == $past(accum) && $stable(flags))
		else $error("first direction load wrong");
	dir_refuse_a: assert property (
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		valid_i && instr_i.op == RSX_PORT_DIRECTION_LOAD_OP &&
		instr_i.addr != DIR_SEL_A && instr_i.addr != DIR_SEL_B
		|=> $stable(dir_a) && $stable(dir_b) && $stable(accum))
		else $error("unnamed direction selector acted on");

	// Literal XOR lands in the accumulator only
	xor_lit_a: assert property (
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		valid_i && instr_i.op == RSX_XOR_LITERAL_ACCUM_OP |=>
		accum == ($past(accum) ^ $past(instr_i.literal)) &&
		flags.carry == $past(flags.carry))
		else $error("literal xor wrong");
	lit_dest_a: assert property (
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		valid_i && instr_i.op == RSX_XOR_LITERAL_ACCUM_OP |=> !file_we)
		else $error("literal xor wrote the file");

	// File XOR and the zero flag of both XOR forms
	xor_file_a: assert property (
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		valid_i && instr_i.op == RSX_XOR_FILE_ACCUM_OP && !instr_i.dest |=>
		accum == ($past(accum) ^ $past(src)) && $stable(flags.carry))
		else $error("file xor wrong");
	zero_flag_a: assert property (
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		valid_i && instr_i.op == RSX_XOR_LITERAL_ACCUM_OP |=>
		flags.zero == (accum == 8'h00))
		else $error("zero flag wrong");
	zero_file_a: assert property (
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		valid_i && instr_i.op == RSX_XOR_FILE_ACCUM_OP |=>
		flags.zero == (($past(accum) ^ $past(src)) == 8'h00))
		else $error("file xor zero flag wrong");

endmodule

// File: bench/rsx_decoder_model.sv
// Behavioural decoder feeding decoded instructions to the slice
`timescale 1ns/100ps
module rsx_decoder_model
	import rsx_pkg::*;
(
	input  wire logic              go_i,    // Issue this cycle
	input  wire rsx_op_type        op_i,    // Operation
	input  wire logic [ADDR_W-1:0] addr_i,  // File address
	input  wire logic              dest_i,  // Destination select
	input  wire logic [DATA_W-1:0] lit_i,   // Literal
	output logic                   valid_o, // Instruction present
	output rsx_instr_type          instr_o  // Packed instruction
);
	// Idle fields show the inverse, so stale values never look valid
	assign valid_o = go_i;
	assign instr_o = go_i ? rsx_instr_type'({op_i, addr_i, dest_i, lit_i})
		: rsx_instr_type'(~{op_i, addr_i, dest_i, lit_i});
endmodule

// File: bench/test_rsx_datapath.sv
// Self-checking testbench for the byte datapath slice
`timescale 1ns/100ps
module test_rsx_datapath;
	import rsx_pkg::*;
	logic              sys_clk_i = 1'b0, reset_n_i = 1'b0;
	logic              go = 1'b0, dest = 1'b0, valid, file_we;
	rsx_op_type        op = RSX_NOP;
	logic [ADDR_W-1:0] addr = 5'h00;
	logic [DATA_W-1:0] lit = 8'h00, accum, dir_a, dir_b, rd_data;
	rsx_instr_type     instr;
	rsx_flags_type     flags;
	int                miscompares = 0, samples_checked = 0, cycles = 0;
	always #25 sys_clk_i = ~sys_clk_i;
	rsx_decoder_model dec (.go_i(go), .op_i(op), .addr_i(addr),
		.dest_i(dest), .lit_i(lit), .valid_o(valid), .instr_o(instr));
	rsx_datapath uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
		.valid_i(valid), .instr_i(instr), .accum_o(accum),
		.flags_o(flags), .dir_a_o(dir_a), .dir_b_o(dir_b),
		.rd_data_o(rd_data), .file_we_o(file_we));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// One instruction; outputs are settled on return
	task run(input rsx_op_type o, input logic [4:0] a, input logic d,
		input logic [7:0] k);
		@(posedge sys_clk_i);
		go <= 1'b1;
		op <= o;
		addr <= a;
		dest <= d;
		lit <= k;
		@(posedge sys_clk_i);
		go <= 1'b0;
		#1;
	endtask
	task end_of_test;
		$display("miscompares=%0d samples_checked=%0d", miscompares,
			samples_checked);
		if (miscompares == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Hang guard: tests need well under 100 cycles
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 300) begin
			miscompares++;
			end_of_test();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		#1;
		chk(accum, 8'h00);
		chk(dir_a, 8'hff);
		chk({6'h00, flags}, 8'h00);
		run(RSX_XOR_LITERAL_ACCUM_OP, 5'h00, 1'b0, 8'ha5);
		chk(accum, 8'ha5);
		chk({6'h00, flags}, 8'h00);
		run(RSX_PORT_DIRECTION_LOAD_OP, 5'h06, 1'b0, 8'h00);
		chk(dir_a, 8'ha5);
		run(RSX_PORT_DIRECTION_LOAD_OP, 5'h05, 1'b0, 8'h00);
		chk(dir_b, 8'hff);
		run(RSX_XOR_LITERAL_ACCUM_OP, 5'h00, 1'b0, 8'hff);
		run(RSX_PORT_DIRECTION_LOAD_OP, 5'h07, 1'b0, 8'h00);
		chk(dir_b, 8'h5a);
		chk(dir_a, 8'ha5);
		run(RSX_XOR_LITERAL_ACCUM_OP, 5'h00, 1'b0, 8'h5a);
		chk(accum, 8'h00);
		chk({6'h00, flags}, 8'h01);
		// File array starts cleared, so write-backs read back defined
		run(RSX_NIBBLE_EXCHANGE_OP, 5'h03, 1'b1, 8'h00);
		chk(accum, 8'h00);
		chk({6'h00, flags}, 8'h01);
		chk({7'h00, file_we}, 8'h01);
		run(RSX_ROTATE_RIGHT_CARRY_OP, 5'h1f, 1'b1, 8'h00);
		chk({7'h00, flags.zero}, 8'h01);
		chk({7'h00, file_we}, 8'h01);
		run(RSX_XOR_FILE_ACCUM_OP, 5'h03, 1'b1, 8'h00);
		chk({7'h00, file_we}, 8'h01);
		run(RSX_NIBBLE_EXCHANGE_OP, 5'h03, 1'b0, 8'h00);
		chk({7'h00, file_we}, 8'h00);
		run(RSX_XOR_LITERAL_ACCUM_OP, 5'h00, 1'b0, 8'h97);
		run(RSX_XOR_FILE_ACCUM_OP, 5'h03, 1'b1, 8'h00);
		chk(accum, 8'h97);
		chk(rd_data, 8'h00);
		chk({6'h00, flags}, 8'h00);
		run(RSX_ROTATE_RIGHT_CARRY_OP, 5'h03, 1'b0, 8'h00);
		chk(accum, 8'h4b);
		chk({6'h00, flags}, 8'h02);
		chk(rd_data, 8'h97);
		run(RSX_ROTATE_RIGHT_CARRY_OP, 5'h03, 1'b1, 8'h00);
		chk(accum, 8'h4b);
		run(RSX_NIBBLE_EXCHANGE_OP, 5'h03, 1'b0, 8'h00);
		chk(rd_data, 8'hcb);
		chk(accum, 8'hbc);
		chk({6'h00, flags}, 8'h02);
		run(RSX_XOR_FILE_ACCUM_OP, 5'h03, 1'b0, 8'h00);
		chk(accum, 8'h77);
		chk({6'h00, flags}, 8'h02);
		run(RSX_NIBBLE_EXCHANGE_OP, 5'h03, 1'b1, 8'h00);
		run(RSX_XOR_LITERAL_ACCUM_OP, 5'h00, 1'b0, 8'hcb);
		run(RSX_XOR_FILE_ACCUM_OP, 5'h03, 1'b1, 8'h00);
		chk(rd_data, 8'hbc);
		chk(accum, 8'hbc);
		chk({6'h00, flags}, 8'h03);
		run(RSX_ROTATE_RIGHT_CARRY_OP, 5'h03, 1'b0, 8'h00);
		chk(accum, 8'h80);
		chk({6'h00, flags}, 8'h01);
		run(RSX_PORT_DIRECTION_LOAD_OP, 5'h06, 1'b0, 8'h00);
		chk(dir_a, 8'h80);
		chk(dir_b, 8'h5a);
		run(RSX_XOR_FILE_ACCUM_OP, 5'h05, 1'b1, 8'h00);
		// Mid-run reset restores every register and clears the file
		@(posedge sys_clk_i);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		#1;
		chk(accum, 8'h00);
		chk(dir_b, 8'hff);
		chk({6'h00, flags}, 8'h00);
		chk({7'h00, file_we}, 8'h00);
		run(RSX_XOR_FILE_ACCUM_OP, 5'h05, 1'b0, 8'h00);
		chk(rd_data, 8'h00);
		chk({6'h00, flags}, 8'h01);
		end_of_test();
	end
endmodule
